/* tcibm_pkg.sv */
package tcibm_pkg;

  localparam int CLK_HZ = 20_000_000;
  // Fastest upstream bus rate the sampling is sized for (R09)
  localparam int BUS_MAX_HZ = 1_000_000;
  localparam int SPIKE_NS = 100;
  localparam int SPIKE_CYC = (SPIKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] FCNT_LAST = 4'(SPIKE_CYC - 1);

  // Upper slave address bits, value is arbitrary
  localparam logic [3:0] ADDR_BASE = 4'he;

  localparam int SYNC_W = 9;
  localparam int SY_UPD = 0;
  localparam int SY_UPC = 1;
  localparam int SY_D0D = 2;
  localparam int SY_D1D = 3;
  localparam int SY_I0 = 4;
  localparam int SY_I1 = 5;
  localparam int SY_ST = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h03f;

  localparam int SEL_EN_BIT = 2;
  localparam int SEL_CH_BIT = 0;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] RD_LAST = 4'h7;
  localparam logic [2:0] HIST_RST = 3'h0;

  typedef struct packed {
    logic clk;
    logic dat;
  } tcibm_line_t;

  localparam tcibm_line_t LINE_IDLE = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR = 7'h08,
    ST_WACK = 7'h10,
    ST_RD = 7'h20,
    ST_RACK = 7'h40
  } tcibm_state_t;

endpackage

/* tcibm_mux.sv */
// Notes on behaviour
// R01: Upstream clock and data are routed to the one selected downstream pair.
// R02: At most one downstream channel is ever connected.
// R03: Reset returns the bus state machine to idle.
// R04: After reset both channels stay disconnected until a new selection is written.
// R05: Upstream interrupt output is the AND of both downstream interrupt inputs.
// R06: Each downstream interrupt input is active low, one per channel.
// R07: Three strap inputs form the low slave address bits, eight addresses.
// R08: Short glitches on upstream clock and data are filtered out; here only for the bus state machine, not the downstream pass-through.
// R09: Serial interface works up to 1 MHz upstream clock.
// R10: One written byte sets the selection; a read returns the current selection.
// R11: A new selection takes effect only at the stop ending the write.
`timescale 1ns/1ps
`default_nettype none
module tcibm_mux
  import tcibm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic up_clock_in,
  input wire logic up_data_in,
  output logic up_data_out,
  output logic up_data_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  output logic up_irq_out_n,
  output logic down0_clock_out,
  output logic down0_clock_oe,
  input wire logic down0_data_in,
  output logic down0_data_out,
  output logic down0_data_oe,
  output logic down1_clock_out,
  output logic down1_clock_oe,
  input wire logic down1_data_in,
  output logic down1_data_out,
  output logic down1_data_oe
);

  logic [SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1;
  tcibm_line_t filt_ff, nxt_filt, prev_ff;
  logic [1:0][3:0] fcnt_ff, nxt_fcnt;
  logic clk_rise, clk_fall, start_evt, stop_evt;
  logic [6:0] own_addr;

  assign up_data_out = 1'b0;
  assign down0_clock_out = 1'b0;
  assign down0_data_out = 1'b0;
  assign down1_clock_out = 1'b0;
  assign down1_data_out = 1'b0;

  // Every input pin except clock and sys_rst passes two flops first
  always_comb begin
    nxt_sync1 = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, chan1_irq_in_n, chan0_irq_in_n,
                 down1_data_in, down0_data_in, up_clock_in, up_data_in};
  end

  // Level follows only after SPIKE_CYC matching samples
  always_comb begin
    nxt_filt = filt_ff;
    nxt_fcnt = fcnt_ff;
    for (int i = 0; i < 2; i++) begin
      if (sync2_ff[i] == filt_ff[i]) begin
        nxt_fcnt[i] = 4'h0;
      end else if (fcnt_ff[i] == FCNT_LAST) begin // [R09]
        nxt_filt[i] = sync2_ff[i]; // [R08]
        nxt_fcnt[i] = 4'h0;
      end else begin
        nxt_fcnt[i] = fcnt_ff[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      filt_ff <= LINE_IDLE;
      prev_ff <= LINE_IDLE;
      fcnt_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= sync1_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
      fcnt_ff <= nxt_fcnt;
    end
  end

  assign clk_rise = filt_ff.clk & ~prev_ff.clk;
  assign clk_fall = ~filt_ff.clk & prev_ff.clk;
  assign start_evt = filt_ff.clk & prev_ff.clk & prev_ff.dat & ~filt_ff.dat;
  assign stop_evt = filt_ff.clk & prev_ff.clk & ~prev_ff.dat & filt_ff.dat;
  assign own_addr = {ADDR_BASE, sync2_ff[SY_ST+2:SY_ST]}; // [R07]

  tcibm_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift, rd_byte;
  logic drv_ff, nxt_drv, rw_ff, nxt_rw, nack_ff, nxt_nack, wr_ff, nxt_wr;
  logic [2:0] pend_ff, nxt_pend, sel_ff, nxt_sel;

  assign rd_byte = {5'h00, sel_ff}; // [R10]

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_drv = drv_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_pend = pend_ff;
    nxt_wr = wr_ff;
    nxt_sel = sel_ff;
    if (start_evt) begin
      nxt_state = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_drv = 1'b0;
    end else if (stop_evt) begin
      nxt_state = ST_IDLE;
      nxt_drv = 1'b0;
      if (wr_ff) begin
        nxt_sel = pend_ff; // [R11]
        nxt_wr = 1'b0;
      end
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR: begin
          if (clk_rise) begin
            nxt_shift = {shift_ff[6:0], filt_ff.dat};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (clk_fall && cnt_ff == BIT_LAST) begin
            if (state_ff == ST_WR) begin
              // Encoding leaves room for one channel only
              nxt_pend = {shift_ff[SEL_EN_BIT], 1'b0, shift_ff[SEL_CH_BIT]}; // [R02] [R10]
              nxt_wr = 1'b1;
              nxt_drv = 1'b1;
              nxt_state = ST_WACK;
            end else if (shift_ff[7:1] == own_addr) begin
              nxt_drv = 1'b1; // [R07]
              nxt_rw = shift_ff[0];
              nxt_state = ST_AACK;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (clk_fall) begin
            nxt_cnt = 4'h0;
            if (rw_ff) begin
              nxt_shift = rd_byte;
              nxt_drv = ~rd_byte[7];
              nxt_state = ST_RD;
            end else begin
              nxt_drv = 1'b0;
              nxt_state = ST_WR;
            end
          end
        end
        ST_WACK: begin
          if (clk_fall) begin
            nxt_drv = 1'b0;
            nxt_cnt = 4'h0;
            nxt_state = ST_WR;
          end
        end
        ST_RD: begin
          if (clk_fall) begin
            if (cnt_ff == RD_LAST) begin
              nxt_drv = 1'b0;
              nxt_state = ST_RACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_drv = ~shift_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (clk_rise) begin
            nxt_nack = filt_ff.dat;
          end else if (clk_fall) begin
            if (nack_ff) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_cnt = 4'h0;
              nxt_shift = rd_byte;
              nxt_drv = ~rd_byte[7];
              nxt_state = ST_RD;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE; // [R03]
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      drv_ff <= 1'b0;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      pend_ff <= SEL_RST;
      wr_ff <= 1'b0;
      sel_ff <= SEL_RST; // [R04]
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      drv_ff <= nxt_drv;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      pend_ff <= nxt_pend;
      wr_ff <= nxt_wr;
      sel_ff <= nxt_sel;
    end
  end

  // Pass-through with direction lockout so neither side latches the other low
  logic sel0, sel1, dn_dat;
  logic dn_drv_ff, nxt_dn_drv, up_pass_ff, nxt_up_pass;
  logic [2:0] dn_hist_ff, nxt_dn_hist, up_hist_ff, nxt_up_hist;
  logic nxt_d0c, nxt_d0d, nxt_d1c, nxt_d1d, nxt_upoe, nxt_irq;

  assign sel0 = sel_ff[SEL_EN_BIT] & ~sel_ff[SEL_CH_BIT];
  assign sel1 = sel_ff[SEL_EN_BIT] & sel_ff[SEL_CH_BIT];
  assign dn_dat = sel1 ? sync2_ff[SY_D1D] : sync2_ff[SY_D0D];

  always_comb begin
    nxt_dn_drv = (sel0 | sel1) & ~sync2_ff[SY_UPD] & ~up_pass_ff & (up_hist_ff == HIST_RST);
    nxt_up_pass = (sel0 | sel1) & ~dn_dat & ~dn_drv_ff & (dn_hist_ff == HIST_RST);
    nxt_dn_hist = {dn_hist_ff[1:0], dn_drv_ff};
    nxt_up_hist = {up_hist_ff[1:0], up_pass_ff};
    nxt_d0c = sel0 & ~sync2_ff[SY_UPC]; // [R01]
    nxt_d1c = sel1 & ~sync2_ff[SY_UPC]; // [R01]
    nxt_d0d = sel0 & nxt_dn_drv; // [R01] [R02]
    nxt_d1d = sel1 & nxt_dn_drv; // [R01] [R02]
    nxt_upoe = nxt_up_pass | drv_ff;
    nxt_irq = sync2_ff[SY_I0] & sync2_ff[SY_I1]; // [R05] [R06]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dn_drv_ff <= 1'b0;
      up_pass_ff <= 1'b0;
      dn_hist_ff <= HIST_RST;
      up_hist_ff <= HIST_RST;
      down0_clock_oe <= 1'b0;
      down1_clock_oe <= 1'b0;
      down0_data_oe <= 1'b0;
      down1_data_oe <= 1'b0;
      up_data_oe <= 1'b0;
      up_irq_out_n <= 1'b1;
    end else begin
      dn_drv_ff <= nxt_dn_drv;
      up_pass_ff <= nxt_up_pass;
      dn_hist_ff <= nxt_dn_hist;
      up_hist_ff <= nxt_up_hist;
      down0_clock_oe <= nxt_d0c;
      down1_clock_oe <= nxt_d1c;
      down0_data_oe <= nxt_d0d;
      down1_data_oe <= nxt_d1d;
      up_data_oe <= nxt_upoe;
      up_irq_out_n <= nxt_irq;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_one_chan;
    !(down0_clock_oe && down1_clock_oe) && !(down0_data_oe && down1_data_oe);
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("two channels driven"); // [R02]

  property p_route0;
    (sel0 && !sync2_ff[SY_UPC]) |=> down0_clock_oe;
  endproperty
  a_route0: assert property (p_route0) else $error("clock not routed to channel 0"); // [R01]

  property p_rst_idle;
    $fell(sys_rst) |-> (state_ff == ST_IDLE && sel_ff == SEL_RST);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset"); // [R03]

  property p_hold_sel;
    !(stop_evt && wr_ff) |=> $stable(sel_ff);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("selection changed without stop"); // [R04]

  property p_sel_apply;
    (stop_evt && wr_ff) |=> (sel_ff == $past(pend_ff));
  endproperty
  a_sel_apply: assert property (p_sel_apply) else $error("selection not applied at stop"); // [R11]

  property p_irq_and;
    $fell(sync2_ff[SY_I0]) |=> !up_irq_out_n;
  endproperty
  a_irq_and: assert property (p_irq_and) else $error("irq output not low"); // [R05]

  property p_irq_hold;
    !chan1_irq_in_n [*4] |-> !up_irq_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("channel 1 irq lost"); // [R06]

  property p_addr_ack;
    (state_ff == ST_ADDR && clk_fall && cnt_ff == BIT_LAST && shift_ff[7:1] == own_addr) |=> drv_ff ##1 up_data_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // [R07]

  property p_filt;
    $changed(filt_ff.clk) |-> (filt_ff.clk == $past(sync2_ff[SY_UPC]) && filt_ff.clk == $past(sync2_ff[SY_UPC], 2));
  endproperty
  a_filt: assert property (p_filt) else $error("clock glitch passed filter"); // [R08]

  property p_read;
    (state_ff == ST_AACK && clk_fall && rw_ff) |=> (state_ff == ST_RD && drv_ff);
  endproperty
  a_read: assert property (p_read) else $error("read byte not started"); // [R10]

  c_sel_ch1: cover property (stop_evt && wr_ff && pend_ff == 3'h5);
  c_read: cover property (state_ff == ST_RACK);
  c_irq: cover property ($fell(up_irq_out_n));
  c_desel: cover property ($fell(sel_ff[SEL_EN_BIT]));

endmodule
`default_nettype wire

/* tcibm_master.sv */
`timescale 1ns/1ps
`default_nettype none
module tcibm_master (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  logic glitch = 1'b0;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Quarter bit of 250 ns, bus at 1 MHz
  task automatic q();
    repeat (5) @(negedge clock);
  endtask
  task automatic start();
    sda_oe = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    logic o;
    sda_oe = !b;
    q();
    scl = 1'b1;
    repeat (3) @(negedge clock);
    o = sda_oe;
    // One-cycle spike on data while clock is high
    sda_oe = o ^ glitch;
    @(negedge clock);
    sda_oe = o;
    r = sda;
    repeat (6) @(negedge clock);
    scl = 1'b0;
    q();
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic byte_rx(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      v = {v[6:0], r};
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

/* tb_two_channel_i2c_bus_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h", $time, a); end end
module tb_two_channel_i2c_bus_mux;
  import tcibm_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] strap = 3'h0;
  logic irq0_n = 1'b1;
  logic irq1_n = 1'b1;
  logic s0_oe = 1'b0;
  logic s1_oe = 1'b0;
  logic seen0 = 1'b0;
  logic seen1 = 1'b0;
  logic seen_clr = 1'b0;
  logic m_scl, m_oe, up_oe, d0c_oe, d1c_oe, d0d_oe, d1d_oe, irq_n;
  int fails = 0;
  int comparisons = 0;
  wire up_sda = !(m_oe | up_oe);
  wire dn0_sda = !(d0d_oe | s0_oe);
  wire dn1_sda = !(d1d_oe | s1_oe);
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    if (seen_clr) begin
      seen0 <= 1'b0;
      seen1 <= 1'b0;
    end else begin
      if (d0c_oe) seen0 <= 1'b1;
      if (d1c_oe) seen1 <= 1'b1;
    end
  end
  task automatic clr_seen();
    seen_clr = 1'b1;
    @(negedge clock);
    seen_clr = 1'b0;
  endtask
  tcibm_mux DUT (.clock(clock), .sys_rst(sys_rst), .up_clock_in(m_scl), .up_data_in(up_sda),
    .up_data_out(), .up_data_oe(up_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .chan0_irq_in_n(irq0_n), .chan1_irq_in_n(irq1_n),
    .up_irq_out_n(irq_n), .down0_clock_out(), .down0_clock_oe(d0c_oe), .down0_data_in(dn0_sda),
    .down0_data_out(), .down0_data_oe(d0d_oe), .down1_clock_out(), .down1_clock_oe(d1c_oe),
    .down1_data_in(dn1_sda), .down1_data_out(), .down1_data_oe(d1d_oe));
  tcibm_master m (.clock(clock), .sda(up_sda), .scl(m_scl), .sda_oe(m_oe));
  task automatic report_and_stop();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    report_and_stop();
  end
  task automatic wr(input logic [7:0] d, input logic exp);
    logic a1, a2;
    m.start();
    m.byte_tx({ADDR_BASE, strap, 1'b0}, a1);
    m.byte_tx(d, a2);
    m.stop();
    `CHK(a1 & a2, exp)
  endtask
  task automatic rd(input logic [7:0] exp);
    logic a;
    logic [7:0] v;
    m.start();
    m.byte_tx({ADDR_BASE, strap, 1'b1}, a);
    m.byte_rx(1'b1, v);
    m.stop();
    `CHK({a, v}, {1'b1, exp})
  endtask
  task automatic t_reset();
    `CHK({up_oe, d0c_oe, d1c_oe, d0d_oe, d1d_oe, irq_n}, 6'h01)
    clr_seen();
    rd(8'h00);
    `CHK({seen1, seen0}, 2'h0)
  endtask
  task automatic t_sel(input logic ch);
    clr_seen();
    wr({5'h00, 1'b1, 1'b0, ch}, 1'b1);
    `CHK(ch ? seen1 : seen0, 1'b0)
    clr_seen();
    rd({5'h00, 1'b1, 1'b0, ch});
    `CHK({seen1, seen0}, ch ? 2'h2 : 2'h1)
  endtask
  task automatic t_strap();
    logic a;
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      repeat (6) @(negedge clock);
      m.start();
      m.byte_tx({ADDR_BASE, strap ^ 3'h1, 1'b0}, a);
      m.stop();
      `CHK(a, 1'b0)
      rd(8'h05);
    end
    strap = 3'h0;
    repeat (6) @(negedge clock);
  endtask
  task automatic t_up();
    // Channel 1 selected: held start must reach only channel 1
    m.start();
    `CHK({d1c_oe, d1d_oe, d0c_oe, d0d_oe}, 4'hc)
    m.stop();
    s1_oe = 1'b1;
    repeat (10) @(negedge clock);
    `CHK(up_oe, 1'b1)
    s1_oe = 1'b0;
    s0_oe = 1'b1;
    repeat (10) @(negedge clock);
    `CHK(up_oe, 1'b0)
    s0_oe = 1'b0;
    repeat (10) @(negedge clock);
  endtask
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      irq0_n = i[0];
      irq1_n = i[1];
      repeat (4) @(negedge clock);
      `CHK(irq_n, i[0] & i[1])
    end
  endtask
  task automatic t_glitch();
    m.glitch = 1'b1;
    wr(8'h04, 1'b1);
    m.glitch = 1'b0;
    rd(8'h04);
  endtask
  task automatic t_midreset();
    logic a;
    m.start();
    m.byte_tx({ADDR_BASE, strap, 1'b0}, a);
    sys_rst = 1'b1;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    m.stop();
    repeat (8) @(negedge clock);
    rd(8'h00);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    repeat (6) @(negedge clock);
    t_reset();
    t_sel(1'b0);
    t_sel(1'b1);
    t_strap();
    t_up();
    t_irq();
    t_glitch();
    t_midreset();
    report_and_stop();
  end
endmodule
`default_nettype wire
